// [core/lst_pkg.sv]
// Package of constants for the logic self-test sequencer
package lst_pkg;
    // Register byte offsets (word aligned)
    localparam logic [31:0] LST_DIV_OFF = 32'hFFFFE108;
    localparam logic [31:0] LST_CTRL_OFF = 32'hFFFFE100;
    localparam logic [31:0] LST_TOUT_OFF = 32'hFFFFE104;
    localparam logic [31:0] LST_STAT_OFF = 32'hFFFFE10C;
    localparam logic [31:0] LST_IRQEN_OFF = 32'hFFFFE110;
    localparam logic [31:0] LST_IRQCLR_OFF = 32'hFFFFE114;
    localparam logic [31:0] LST_FAILIV_OFF = 32'hFFFFE118;
    // Control fields
    localparam int LST_CTRL_EN_BIT = 0;
    localparam int LST_CTRL_RESTART_BIT = 1;
    localparam int LST_CTRL_CNT_LSB = 8;
    localparam int LST_CNT_W = 5;
    // Status fields
    localparam int LST_ST_DONE_BIT = 0;
    localparam int LST_ST_FAIL_BIT = 1;
    localparam int LST_ST_TOUT_BIT = 2;
    localparam int LST_ST_W = 3;
    // Divider field
    localparam int LST_DIV_W = 3;
    // Engine timing
    localparam int LST_IV_CYCLES = 1365;
    localparam int LST_MAX_IV = 24;
    localparam logic [31:0] LST_TOUT_RESET = 32'h0000FFFF;
    localparam int LST_RST_CYCLES = 8;
    // Sequencer states
    typedef enum logic [3:0] {
        LST_IDLE = 4'h1,
        LST_RUN = 4'h2,
        LST_RST = 4'h4,
        LST_WAIT = 4'h8
    } lst_state_t;
endpackage

// [core/lst_engine.sv]
// Deterministic test engine stand-in: runs one interval on enable pulses
`timescale 1ns/1ps
module lst_engine import lst_pkg::*; #(
    parameter int IV_CYCLES = LST_IV_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Interval control
    input wire logic tick,
    input wire logic start,
    input wire logic sig_ok,
    output logic iv_done,
    output logic iv_fail
);
    localparam int CW = $clog2(IV_CYCLES + 1);
    logic [CW-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic fail_q, fail_d;

    // Counts self-test clock ticks of one interval, then compares signature
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        fail_d = 1'b0;
        if (start) begin
            busy_d = 1'b1;
            cnt_d = '0;
        end else if (busy_q && tick) begin
            if (cnt_q == CW'(IV_CYCLES - 1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                fail_d = ~sig_ok;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            fail_q <= fail_d;
        end
    end

    assign iv_done = done_q;
    assign iv_fail = fail_q;
endmodule

// [core/lst_seq.sv]
// Logic self-test sequencer top with APB registers
// Functional notes
// - Cores are tested by driving a deterministic logic test engine.
// - A run is split into intervals and software picks how many run.
// - A run may cover the whole test or only a few intervals.
// - A run resumes after the last interval or restarts at the first.
// - The cores under test are isolated from the system during a run.
// - The number of a failing interval is recorded for software.
// - A programmable timeout ends the run and flags failure.
// - A run ends with a processor reset; software reads status after.
// - The test clock is the core clock divided by the divider register value plus one.
// - Each interval is 1365 test clock cycles, up to 24 intervals.
// - The divide ratio field selects any ratio from 1 to 8.
// - The delayed core clock is divided by the same ratio in a run.
`timescale 1ns/1ps
module lst_seq import lst_pkg::*; #(
    parameter int IV_CYCLES = LST_IV_CYCLES,
    parameter int MAX_IV = LST_MAX_IV
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Engine signature result from the cores
    input wire logic sig_ok_pin,
    // Core side controls
    output logic core_isolate,
    output logic core_clk_en,
    output logic delayed_clk_en,
    output logic cpu_reset,
    // Interrupt
    output logic irq
);
    localparam int IW = $clog2(MAX_IV + 1);

    lst_state_t st_q, st_d;
    logic en_q, en_d;
    logic restart_q, restart_d;
    logic [LST_CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0] tout_q, tout_d;
    logic [LST_DIV_W-1:0] div_q, div_d;
    logic [LST_DIV_W-1:0] dcnt_q, dcnt_d;
    logic tick_q, tick_d;
    logic [31:0] tcnt_q, tcnt_d;
    logic [IW-1:0] next_iv_q, next_iv_d;
    logic [IW-1:0] run_left_q, run_left_d;
    logic [IW-1:0] fail_iv_q, fail_iv_d;
    logic [LST_ST_W-1:0] stat_q, stat_d;
    logic [LST_ST_W-1:0] irqen_q, irqen_d;
    logic [3:0] rcnt_q, rcnt_d;
    logic start_q, start_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    logic sig_s1_q, sig_s2_q;
    logic iv_done, iv_fail;
    logic wr, rd, hit;
    logic [LST_ST_W-1:0] set_ev, clr_ev;

    // Pin synchroniser for the signature result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_s1_q <= 1'b0;
            sig_s2_q <= 1'b0;
        end else begin
            sig_s1_q <= sig_ok_pin;
            sig_s2_q <= sig_s1_q;
        end
    end

    // Test engine doing the actual pattern work
    lst_engine #(.IV_CYCLES(IV_CYCLES)) i_lst_engine (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .start(start_q),
        .sig_ok(sig_s2_q),
        .iv_done(iv_done),
        .iv_fail(iv_fail)
    );

    // APB: reads fetched on the first access edge, writes land on the edge
    // that shows pready, so nothing commits before the master sees it
    assign wr = psel && penable && pwrite && pready_q;
    assign rd = psel && penable && !pwrite && !pready_q;
    always_comb begin
        hit = 1'b1;
        unique case (paddr)
            LST_CTRL_OFF, LST_TOUT_OFF, LST_DIV_OFF, LST_STAT_OFF,
            LST_IRQEN_OFF, LST_IRQCLR_OFF, LST_FAILIV_OFF: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Register file and bus answer
    always_comb begin
        en_d = en_q;
        restart_d = restart_q;
        cnt_d = cnt_q;
        tout_d = tout_q;
        div_d = div_q;
        irqen_d = irqen_q;
        clr_ev = '0;
        prdata_d = prdata_q;
        pready_d = psel && penable && !pready_q;
        pslverr_d = psel && penable && !pready_q && !hit;
        if (wr && st_q == LST_IDLE) begin
            unique case (paddr)
                LST_CTRL_OFF: begin
                    en_d = pwdata[LST_CTRL_EN_BIT];
                    restart_d = pwdata[LST_CTRL_RESTART_BIT];
                    cnt_d = pwdata[LST_CTRL_CNT_LSB +: LST_CNT_W];
                end
                LST_TOUT_OFF: tout_d = pwdata;
                LST_DIV_OFF: div_d = pwdata[LST_DIV_W-1:0];
                default: ;
            endcase
        end
        if (wr) begin
            if (paddr == LST_IRQEN_OFF) irqen_d = pwdata[LST_ST_W-1:0];
            if (paddr == LST_IRQCLR_OFF) clr_ev = pwdata[LST_ST_W-1:0];
        end
        if (rd) begin
            prdata_d = '0;
            unique case (paddr)
                LST_CTRL_OFF: begin
                    prdata_d[LST_CTRL_EN_BIT] = en_q;
                    prdata_d[LST_CTRL_RESTART_BIT] = restart_q;
                    prdata_d[LST_CTRL_CNT_LSB +: LST_CNT_W] = cnt_q;
                end
                LST_TOUT_OFF: prdata_d = tout_q;
                LST_DIV_OFF: prdata_d[LST_DIV_W-1:0] = div_q;
                LST_STAT_OFF: prdata_d[LST_ST_W-1:0] = stat_q;
                LST_IRQEN_OFF: prdata_d[LST_ST_W-1:0] = irqen_q;
                LST_FAILIV_OFF: prdata_d[IW-1:0] = fail_iv_q;
                default: ;
            endcase
        end
        if (st_q == LST_RST) begin
            en_d = 1'b0;
        end
    end

    // Divided self-test clock enable: ratio field value plus one
    // Counts from the entry edge, so the first test period is not stretched
    always_comb begin
        dcnt_d = dcnt_q;
        tick_d = 1'b0;
        if (st_d == LST_RUN) begin
            if (dcnt_q == div_q) begin
                dcnt_d = '0;
                tick_d = 1'b1;
            end else begin
                dcnt_d = dcnt_q + LST_DIV_W'(1);
            end
        end else begin
            dcnt_d = '0;
        end
    end

    // Run sequencing, timeout and failure capture
    always_comb begin
        st_d = st_q;
        tcnt_d = tcnt_q;
        next_iv_d = next_iv_q;
        run_left_d = run_left_q;
        fail_iv_d = fail_iv_q;
        rcnt_d = rcnt_q;
        start_d = 1'b0;
        set_ev = '0;
        unique case (st_q)
            LST_IDLE: begin
                if (en_q) begin
                    st_d = LST_RUN;
                    tcnt_d = '0;
                    run_left_d = (cnt_q == '0) ? IW'(MAX_IV) : IW'(cnt_q);
                    if (restart_q || next_iv_q >= IW'(MAX_IV)) begin
                        next_iv_d = '0;
                    end
                    start_d = 1'b1;
                end
            end
            LST_RUN: begin
                tcnt_d = tcnt_q + 32'h00000001;
                if (tcnt_q >= tout_q) begin
                    set_ev[LST_ST_TOUT_BIT] = 1'b1;
                    set_ev[LST_ST_FAIL_BIT] = 1'b1;
                    st_d = LST_RST;
                end else if (iv_done) begin
                    next_iv_d = next_iv_q + IW'(1);
                    run_left_d = run_left_q - IW'(1);
                    if (iv_fail) begin
                        fail_iv_d = next_iv_q + IW'(1);
                        set_ev[LST_ST_FAIL_BIT] = 1'b1;
                        st_d = LST_RST;
                    end else if (run_left_q == IW'(1) ||
                                 next_iv_q == IW'(MAX_IV - 1)) begin
                        set_ev[LST_ST_DONE_BIT] = 1'b1;
                        st_d = LST_RST;
                    end else begin
                        start_d = 1'b1;
                    end
                end
            end
            LST_RST: begin
                rcnt_d = '0;
                st_d = LST_WAIT;
            end
            LST_WAIT: begin
                rcnt_d = rcnt_q + 4'h1;
                if (rcnt_q == 4'(LST_RST_CYCLES - 1)) begin
                    st_d = LST_IDLE;
                end
            end
            default: st_d = LST_IDLE;
        endcase
        // Set beats clear so no event is lost
        stat_d = (stat_q & ~clr_ev) | set_ev;
        irq_d = |(stat_d & irqen_q);
    end

    // State and register flops; status is not touched by cpu_reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= LST_IDLE;
            en_q <= 1'b0;
            restart_q <= 1'b0;
            cnt_q <= '0;
            tout_q <= LST_TOUT_RESET;
            div_q <= '0;
            dcnt_q <= '0;
            tick_q <= 1'b0;
            tcnt_q <= '0;
            next_iv_q <= '0;
            run_left_q <= '0;
            fail_iv_q <= '0;
            stat_q <= '0;
            irqen_q <= '0;
            rcnt_q <= '0;
            start_q <= 1'b0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            en_q <= en_d;
            restart_q <= restart_d;
            cnt_q <= cnt_d;
            tout_q <= tout_d;
            div_q <= div_d;
            dcnt_q <= dcnt_d;
            tick_q <= tick_d;
            tcnt_q <= tcnt_d;
            next_iv_q <= next_iv_d;
            run_left_q <= run_left_d;
            fail_iv_q <= fail_iv_d;
            stat_q <= stat_d;
            irqen_q <= irqen_d;
            rcnt_q <= rcnt_d;
            start_q <= start_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    // Core side outputs, all registered
    logic iso_q, cen_q, rst_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iso_q <= 1'b0;
            cen_q <= 1'b1;
            rst_q <= 1'b0;
        end else begin
            iso_q <= (st_d == LST_RUN);
            // Both core clock trees gated by one divided enable
            cen_q <= (st_d == LST_RUN) ? tick_d : 1'b1;
            rst_q <= (st_d == LST_RST) || (st_d == LST_WAIT);
        end
    end

    assign core_isolate = iso_q;
    assign core_clk_en = cen_q;
    assign delayed_clk_en = cen_q;
    assign cpu_reset = rst_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule

// [bench/lst_seq_sva.sv]
// Port checker for the logic self-test sequencer
`timescale 1ns/1ps
module lst_seq_sva import lst_pkg::*; #(
    parameter int IV_CYCLES = LST_IV_CYCLES,
    parameter int MAX_IV = LST_MAX_IV
) (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core side
    input wire logic core_isolate,
    input wire logic core_clk_en,
    input wire logic delayed_clk_en,
    input wire logic cpu_reset
);
    logic [2:0] div_q;
    logic [2:0] div_d;
    logic [3:0] gap_q;
    logic [3:0] gap_d;
    // Divider copy taken whenever the cores are not isolated, since run writes are refused
    always_comb begin
        div_d = div_q;
        if (psel && penable && pready && pwrite && !core_isolate &&
            paddr == LST_DIV_OFF) begin
            div_d = pwdata[2:0];
        end
        gap_d = core_clk_en ? 4'h0 : gap_q + 4'h1;
    end
    // Helper registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 3'h0;
            gap_q <= 4'h0;
        end else begin
            div_q <= div_d;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rdy_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_rdy_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer on second access cycle");
    a_err_rdy: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_clk: assert property (!core_isolate && !$past(core_isolate)
        |-> core_clk_en) else $error("core clock gated while idle");
    a_dly_same: assert property (delayed_clk_en == core_clk_en)
        else $error("delayed clock enable differs");
    a_rst_len: assert property ($rose(cpu_reset)
        |=> cpu_reset [*8] ##1 !cpu_reset) else $error("cpu reset length");
    a_rst_free: assert property ($rose(cpu_reset)
        |=> !core_isolate [*8]) else $error("isolation kept after run");
    a_clk_gap: assert property (core_isolate && $past(core_isolate)
        |-> gap_q <= {1'h0, div_q}) else $error("divided clock gap");
endmodule
bind lst_seq lst_seq_sva #(.IV_CYCLES(IV_CYCLES), .MAX_IV(MAX_IV)) i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .core_isolate(core_isolate),
    .core_clk_en(core_clk_en), .delayed_clk_en(delayed_clk_en),
    .cpu_reset(cpu_reset));

// [bench/lst_cores.sv]
// Model of the two lockstep cores answering with a signature result
`timescale 1ns/1ps
module lst_cores (
    // Clock and run state
    input wire logic pclk,
    input wire logic core_isolate,
    // Fault injection from the bench
    input wire logic bad,
    // Signature result
    output logic sig_ok_pin
);
    initial sig_ok_pin = 1'h0;
    // Result only meaningful in a run; toggles otherwise so no stale level
    always @(posedge pclk) begin
        sig_ok_pin <= core_isolate ? !bad : !sig_ok_pin;
    end
endmodule

// [bench/tb.sv]
// Self-checking bench for the logic self-test sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb;
    import lst_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, bad = 1'h0, er;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sig_ok_pin, core_isolate, core_clk_en;
    logic delayed_clk_en, cpu_reset, irq;
    int err_total = 0, n_compared = 0, cyc = 0;
    initial forever #50 pclk = ~pclk;
    // Short intervals keep runs brief
    lst_seq #(.IV_CYCLES(4)) i_lst_seq (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sig_ok_pin(sig_ok_pin),
        .core_isolate(core_isolate), .core_clk_en(core_clk_en),
        .delayed_clk_en(delayed_clk_en), .cpu_reset(cpu_reset), .irq(irq));
    lst_cores i_lst_cores (.pclk(pclk), .core_isolate(core_isolate),
        .bad(bad), .sig_ok_pin(sig_ok_pin));
    task final_report;
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready, then an idle cycle
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1);
        `CHK(n, 2)
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Run end is marked by the processor reset pulse
    task wait_end;
        int n;
        n = 0;
        while (cpu_reset !== 1'h1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        `CHK(cpu_reset, 1'h1)
        while (cpu_reset === 1'h1) @(posedge pclk);
    endtask
    task chk_irq(input logic e);
        repeat (2) @(posedge pclk);
        `CHK(irq, e)
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, LST_TOUT_OFF, 32'h0);
        `CHK(rd, LST_TOUT_RESET)
        apb(1'h0, LST_STAT_OFF, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'h0, 32'hFFFFE11C, 32'h0);
        `CHK(er, 1'h1)
        apb(1'h1, LST_DIV_OFF, 32'h1);
        // Two intervals from the first; divider write refused mid-run
        apb(1'h1, LST_CTRL_OFF, 32'h203);
        repeat (2) @(posedge pclk);
        `CHK(core_isolate, 1'h1)
        apb(1'h1, LST_DIV_OFF, 32'h5);
        wait_end;
        apb(1'h0, LST_DIV_OFF, 32'h0);
        `CHK(rd[2:0], 3'h1)
        apb(1'h0, LST_STAT_OFF, 32'h0);
        `CHK(rd[2:0], 3'h1)
        apb(1'h0, LST_CTRL_OFF, 32'h0);
        `CHK(rd[0], 1'h0)
        `CHK(irq, 1'h0)
        apb(1'h1, LST_IRQEN_OFF, 32'h7);
        chk_irq(1'h1);
        apb(1'h1, LST_IRQCLR_OFF, 32'h7);
        chk_irq(1'h0);
        // Resume one interval with a bad signature: third interval fails
        bad <= 1'h1;
        apb(1'h1, LST_CTRL_OFF, 32'h101);
        wait_end;
        apb(1'h0, LST_FAILIV_OFF, 32'h0);
        `CHK(rd[4:0], 5'h3)
        apb(1'h0, LST_STAT_OFF, 32'h0);
        `CHK(rd[1], 1'h1)
        `CHK(irq, 1'h1)
        apb(1'h1, LST_IRQCLR_OFF, 32'h7);
        apb(1'h1, LST_CTRL_OFF, 32'h203);
        wait_end;
        apb(1'h0, LST_FAILIV_OFF, 32'h0);
        `CHK(rd[4:0], 5'h1)
        // Full run at ratio 8 cut short by a tiny timeout
        bad <= 1'h0;
        apb(1'h1, LST_IRQCLR_OFF, 32'h7);
        apb(1'h1, LST_DIV_OFF, 32'h7);
        apb(1'h0, LST_DIV_OFF, 32'h0);
        `CHK(rd[2:0], 3'h7)
        apb(1'h1, LST_TOUT_OFF, 32'h5);
        apb(1'h1, LST_CTRL_OFF, 32'h3);
        wait_end;
        apb(1'h0, LST_STAT_OFF, 32'h0);
        `CHK(rd[2:1], 2'h3)
        final_report;
    end
endmodule
